//--- hdl/clock_config_defines.vh
// constants for the clock configuration word block
// assumes a 32-bit AXI4-Lite register space, byte addressed
`ifndef CLOCK_CONFIG_DEFINES_VH
`define CLOCK_CONFIG_DEFINES_VH
// ==========================================================
// register map
`define CLOCK_CONFIG_ZERO_OFFSET 12'h004
`define CLOCK_CONFIG_ZERO_RESET 32'h00020000
// writable bits of the upper half handled here (bits 23:22 reserved)
`define CLOCK_CONFIG_ZERO_RW_MASK 32'hff3fffff
// ==========================================================
// field positions
`define HALVING_BIT 31
`define OUT_DIV_HI 30
`define OUT_DIV_LO 28
`define MF_TOP_BIT 27
`define OUT_SRC_HI 26
`define OUT_SRC_LO 24
`define MF_LOW_HI 21
`define MF_LOW_LO 18
// ==========================================================
// output source codes
`define SRC_NONE 3'h0
`define SRC_RSVD 3'h1
`define SRC_RC40K 3'h2
`define SRC_LXTAL 3'h3
`define SRC_SYS 3'h4
`define SRC_RC8M 3'h5
`define SRC_HXTAL 3'h6
`define SRC_PLL 3'h7
// ==========================================================
// axi response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

//--- hdl/pll_factor_and_clock_out_config.v
// configuration word for pll multiplier and clock output path, with axi4-lite slave
// assumes source clocks arrive as plain inputs already in the bus clock domain's reach;
// slow clocks are synchronised here before the output mux samples them
//
// Summary of operation
// - word at 0x04, resets to 0x00020000
// - bit31 zero halves pll clock for output
// - bits 30:28 divide output by power two
// - bits 26:24 choose output clock source
// - code 111 picks pll, halved per bit31
// - five-bit factor from bit27 and 21:18
// - codes 0..14 give factor code plus two
// - code 15 also gives factor 16
// - codes 16..28 give factor code plus one
// - code 29 gives 30; 30,31 give 31
`timescale 1ns/100ps
`default_nettype none
`include "clock_config_defines.vh"
module pll_factor_and_clock_out_config (
  input wire clock,
  input wire rst,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire rc40kClock,
  input wire lxtalClock,
  input wire sysClockTap,
  input wire rc8mClock,
  input wire hxtalClock,
  input wire pll_clock,
  output reg [4:0] pllMultiplier,
  output reg [2:0] clock_output_source,
  output reg clock_output
);

  // ==========================================================
  // functions
  // maps the 5-bit code to the actual multiplication factor
  function [4:0] decode_factor;
    input [4:0] code;
    begin
      if (code <= 5'h0e) begin
        decode_factor = code + 5'h02;
      end else if (code == 5'h0f) begin
        decode_factor = 5'h10;
      end else if (code <= 5'h1c) begin
        decode_factor = code + 5'h01;
      end else if (code == 5'h1d) begin
        decode_factor = 5'h1e;
      end else begin
        decode_factor = 5'h1f;
      end
    end
  endfunction

  function [31:0] merge_strobes;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      merge_strobes = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge_strobes[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // ==========================================================
  // register and bus state
  reg [31:0] configWord_reg;
  reg [11:0] awAddr_reg;
  reg awHeld_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;
  reg wHeld_reg;
  wire [4:0] factorCode;
  wire [2:0] outDivCode;
  wire [2:0] outSrcCode;
  wire halveOff;
  // word index compared on bits 11:2, so byte lanes inside the word alias
  localparam [11:0] CFG_OFFSET = `CLOCK_CONFIG_ZERO_OFFSET;

  assign factorCode = {configWord_reg[`MF_TOP_BIT], configWord_reg[`MF_LOW_HI:`MF_LOW_LO]};
  assign outDivCode = configWord_reg[`OUT_DIV_HI:`OUT_DIV_LO];
  assign outSrcCode = configWord_reg[`OUT_SRC_HI:`OUT_SRC_LO];
  assign halveOff = configWord_reg[`HALVING_BIT];

  // ==========================================================
  // write channel: address and data taken in either order, response after both
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      configWord_reg <= `CLOCK_CONFIG_ZERO_RESET;
      awAddr_reg <= 12'h000;
      awHeld_reg <= 1'b0;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      wHeld_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_awvalid && !awHeld_reg && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
        awHeld_reg <= 1'b1;
      end
      if (s_axi_wvalid && !wHeld_reg && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
        wHeld_reg <= 1'b1;
      end
      if (awHeld_reg && wHeld_reg && !s_axi_bvalid) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // reserved bits forced zero, so a careless write cannot set them
        if (awAddr_reg[11:2] == CFG_OFFSET[11:2]) begin
          configWord_reg <= merge_strobes(configWord_reg, wData_reg, wStrb_reg)
                            & `CLOCK_CONFIG_ZERO_RW_MASK;
          s_axi_bresp <= `RESP_OKAY;
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // read channel: one-cycle accept, data in the same cycle as the accept
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        if (s_axi_araddr[11:2] == CFG_OFFSET[11:2]) begin
          s_axi_rdata <= configWord_reg & `CLOCK_CONFIG_ZERO_RW_MASK;
          s_axi_rresp <= `RESP_OKAY;
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // source sampling: every clock input crosses two flops before use
  reg [5:0] srcMeta_reg;
  reg [5:0] srcSync_reg;
  reg pllHalf_reg;
  reg pllSyncPrev_reg;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      srcMeta_reg <= 6'h00;
      srcSync_reg <= 6'h00;
      pllHalf_reg <= 1'b0;
      pllSyncPrev_reg <= 1'b0;
    end else begin
      srcMeta_reg <= {pll_clock, hxtalClock, rc8mClock, sysClockTap, lxtalClock, rc40kClock};
      srcSync_reg <= srcMeta_reg;
      pllSyncPrev_reg <= srcSync_reg[5];
      // halved pll: toggle on each rising edge of the sampled pll clock
      if (srcSync_reg[5] && !pllSyncPrev_reg) begin
        pllHalf_reg <= ~pllHalf_reg;
      end
    end
  end

  // ==========================================================
  // source mux
  reg selected;
  always @* begin
    case (outSrcCode)
      `SRC_RC40K: selected = srcSync_reg[0];
      `SRC_LXTAL: selected = srcSync_reg[1];
      `SRC_SYS: selected = srcSync_reg[2];
      `SRC_RC8M: selected = srcSync_reg[3];
      `SRC_HXTAL: selected = srcSync_reg[4];
      `SRC_PLL: selected = halveOff ? srcSync_reg[5] : pllHalf_reg;
      default: selected = 1'b0; // none and reserved give no clock
    endcase
  end

  // ==========================================================
  // power-of-two divider: a 7-bit ripple count on selected rising edges
  // sampling limits usable output to well under the bus clock; a real part uses gated cells
  reg selectedPrev_reg;
  reg [6:0] divCount_reg;
  wire [7:0] divChain;
  wire noClock;
  assign divChain = {divCount_reg, selected};
  assign noClock = (outSrcCode == `SRC_NONE) || (outSrcCode == `SRC_RSVD);
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      selectedPrev_reg <= 1'b0;
      divCount_reg <= 7'h00;
      clock_output <= 1'b0;
      pllMultiplier <= 5'h02;
      clock_output_source <= `SRC_NONE;
    end else begin
      selectedPrev_reg <= selected;
      // a stopped source clears the count so the divider restarts from zero; the pin itself is forced low by noClock
      if (noClock) begin
        divCount_reg <= 7'h00;
      end else if (selected && !selectedPrev_reg) begin
        divCount_reg <= divCount_reg + 7'h01;
      end
      clock_output <= noClock ? 1'b0 : divChain[outDivCode];
      pllMultiplier <= decode_factor(factorCode);
      clock_output_source <= outSrcCode;
    end
  end

endmodule // pll_factor_and_clock_out_config
`default_nettype wire

//--- testbench/pll_cfg_checker_asserts.sv
// port assertions for the clock configuration word block
// assumes it is bound to that block and sees its ports only
`timescale 1ns/100ps
`default_nettype none
// ====
// checker
module pll_cfg_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [4:0] pllMultiplier,
  input wire logic [2:0] clock_output_source,
  input wire logic clock_output
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // answers stand until taken; factor and source outputs move only after a write answer
  writeHold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  readHold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
  writeCause_a: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awready || s_axi_wready))
    else $error("bvalid uncaused");
  rsvdZero_a: assert property (s_axi_rvalid |-> s_axi_rdata[23:22] == 2'h0) else $error("reserved set");
  errZero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0) else $error("err data");
  mfRange_a: assert property (pllMultiplier >= 5'h02) else $error("factor low");
  cfgHold_a: assert property (!$past(s_axi_bvalid) && !$past(s_axi_bvalid, 2)
    |-> $stable({pllMultiplier, clock_output_source})) else $error("output moved");
  quietOut_a: assert property (clock_output_source == 3'h0 [*8] |-> !clock_output) else $error("clock on none");
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cover property (clock_output_source == 3'h7 && clock_output);
  cover property (pllMultiplier == 5'h1f);
endmodule // pll_cfg_checker
bind pll_factor_and_clock_out_config pll_cfg_checker i_chk (.clock, .rst, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .pllMultiplier,
  .clock_output_source, .clock_output);
`default_nettype wire

//--- testbench/test_pll_factor_and_clock_out_config.sv
// self-checking bench for the clock configuration word block
// assumes the design, its header and the checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module test_pll_factor_and_clock_out_config;
  // ====
  // signals; source clocks come from one counter, well below the bus rate
  logic clock = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, clock_output, prev;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, bq[$];
  logic [4:0] pllMultiplier, curMf = 5'h02;
  logic [2:0] clock_output_source, curSrc = 3'h0;
  logic [7:0] cnt = 8'h00;
  logic [41:0] note, rq[$];
  logic [31:0] cfg[12] = '{32'h04000000, 32'h14000000, 32'h24000000, 32'h07000000, 32'h87000000, 32'h02000000,
    32'h03000000, 32'h05000000, 32'h06000000, 32'h36000000, 32'h70000000, 32'h71000000};
  int rises[12] = '{16, 8, 4, 16, 32, 2, 4, 8, 64, 8, 0, 0};
  int mismatches = 0, checks = 0, n;
  wire hxtalClock = cnt[1], pll_clock = cnt[2], sysClockTap = cnt[3], rc8mClock = cnt[4];
  wire lxtalClock = cnt[5], rc40kClock = cnt[6];
  always #4 clock = ~clock;
  always @(posedge clock) cnt <= cnt + 8'h01;
  pll_factor_and_clock_out_config i_dut (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .rc40kClock, .lxtalClock, .sysClockTap, .rc8mClock, .hxtalClock, .pll_clock, .pllMultiplier,
    .clock_output_source, .clock_output);
  // ====
  // helpers; expected factor worked out from the code table
  function automatic logic [4:0] fac(input logic [4:0] c);
    return c < 15 ? c + 5'd2 : c == 15 ? 5'd16 : c < 29 ? c + 5'd1 : c == 29 ? 5'd30 : 5'd31;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (mismatches == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // both write channels offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] r);
    @(posedge clock);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] v, input logic [1:0] r);
    @(posedge clock);
    rq.push_back({v, r, curMf, curSrc});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  // ====
  // monitor: oldest note against each answer; low fields lie outside this block
  always @(posedge clock) begin
    if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp, bq.pop_front());
    if (s_axi_rvalid && s_axi_rready) begin
      note = rq.pop_front();
      chk(s_axi_rdata & 32'hfffc0000, note[41:10]);
      chk(s_axi_rresp, note[9:8]);
      chk(pllMultiplier, note[7:3]);
      chk(clock_output_source, note[2:0]);
    end
  end
  // ====
  // main sequence and watchdog
  initial begin
    void'($urandom(32'ha5ca240d));
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rd(12'h004, 32'h0, 2'h0);
    for (int i = 0; i < 32; i++) begin
      d[31:24] = 8'($urandom);
      d[27] = i[4];
      d[26:24] = i[2:0];
      d[23:0] = {2'h0, i[3:0], 18'h0};
      curMf = fac({d[27], d[21:18]});
      curSrc = d[26:24];
      wr(12'h004, d, 2'h0);
      rd(12'h004, d, 2'h0);
    end
    wr(12'h008, 32'h80000000, 2'h2);
    rd(12'h004, d, 2'h0);
    rd(12'h008, 32'h0, 2'h2);
    for (int k = 0; k < 12; k++) begin
      wr(12'h004, cfg[k], 2'h0);
      repeat (16) @(posedge clock);
      n = 0;
      repeat (256) begin
        @(posedge clock);
        n += int'(clock_output && !prev);
        prev = clock_output;
      end
      chk(32'(n >= rises[k] - 1 && n <= rises[k] + 1), 32'h1);
    end
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    finish_test;
  end
endmodule // test_pll_factor_and_clock_out_config
`default_nettype wire
